// ### rtl/mpu_top.sv
/*
  Memory protection unit: AHB-Lite register slave, eight regions plus
  a background map, and a same-cycle check of fetches and data accesses.
  Assumes the core presents one access at a time, synchronous to hclk,
  and flags when it runs at priority -1 or -2.
*/
`timescale 1ns/1ns
`default_nettype none

// Function
// - Eight regions 0-7 plus background region
// - Highest-numbered matching region wins
// - Same regions check fetches and data
// - Prohibited access raises memory management fault
// - Capability reads zero, eight, unified map
// - Enabled, no default map: miss faults
// - Default map backs privileged only, lowest
// - Default map bit ignored when disabled
// - Bypass in high-priority handlers unless enabled
// - Bypass exactly at priority minus one/two
// - Disabled: default map for all accesses
// - Unprivileged miss faults with default map
// - Control space always execute-never, strongly ordered
// - Control space data accesses and vectors always permitted
// - Strongly ordered regions: in order, shared
// - Three alias pairs share primary storage
// - Region select picks region zero to seven
// - Valid base write updates select; reads zero
// - Size is two to field plus one
// - Execute-never region faults instruction fetches
module mpu_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Access from the core
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_fetch,
  input wire logic acc_write,
  input wire logic acc_priv,
  input wire logic acc_hi_prio,
  // Decision and attributes
  output logic acc_fault,
  output logic acc_region_hit,
  output logic [2:0] acc_region,
  output logic acc_default_map,
  output logic acc_xn,
  output logic acc_strong_order,
  output logic acc_shareable,
  output logic [4:0] acc_mem_attr
);

  ////////////////////////////////////////////////////////////////////////
  // Register port state
  mpu_pkg::mpu_bus_st_t st_q;
  mpu_pkg::mpu_bus_st_t st_d;
  logic [31:0] a_q;
  logic sz_ok_q;
  logic [31:0] rdata_q;

  // Storage
  logic [2:0] ctrl_q;
  logic [2:0] rsel_q;
  logic [26:0] base_q [mpu_pkg::MPU_NREG];
  logic [31:0] region_attr_size_q [mpu_pkg::MPU_NREG];

  // Address phase taken on a ready cycle with a transfer
  wire logic ap_take = hsel & htrans[1] & hready;

  // Next bus state
  always_comb begin
    st_d = st_q;
    case (st_q)
      mpu_pkg::MPU_BUS_RD: begin
        st_d = mpu_pkg::MPU_BUS_RDO;
      end
      mpu_pkg::MPU_BUS_IDLE, mpu_pkg::MPU_BUS_WR,
      mpu_pkg::MPU_BUS_RDO: begin
        if (ap_take) begin
          st_d = hwrite ? mpu_pkg::MPU_BUS_WR : mpu_pkg::MPU_BUS_RD;
        end else begin
          st_d = mpu_pkg::MPU_BUS_IDLE;
        end
      end
      default: begin
        st_d = mpu_pkg::MPU_BUS_IDLE;
      end
    endcase
  end

  // Bus state and captured address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= mpu_pkg::MPU_BUS_IDLE;
      a_q <= 32'h00000000;
      sz_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (ap_take) begin
        a_q <= haddr;
        sz_ok_q <= (hsize == mpu_pkg::HSIZE_WORD);
      end
    end
  end

  // Reads take one wait state; response is always OKAY
  assign hreadyout = (st_q != mpu_pkg::MPU_BUS_RD);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Write decode, only whole-word writes land
  wire logic wr_ok = (st_q == mpu_pkg::MPU_BUS_WR) & sz_ok_q;
  wire logic is_base = (a_q == mpu_pkg::MPU_RBASE_ADDR) |
                       (a_q == mpu_pkg::MPU_RBASE_A1_ADDR) |
                       (a_q == mpu_pkg::MPU_RBASE_A2_ADDR) |
                       (a_q == mpu_pkg::MPU_RBASE_A3_ADDR);
  wire logic is_region_attr_size = (a_q == mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR) |
                       (a_q == mpu_pkg::MPU_REGION_ATTR_SIZE_ALIAS_1_ADDR) |
                       (a_q == mpu_pkg::MPU_REGION_ATTR_SIZE_ALIAS_2_ADDR) |
                       (a_q == mpu_pkg::MPU_REGION_ATTR_SIZE_ALIAS_3_ADDR);
  wire logic wr_ctrl = wr_ok & (a_q == mpu_pkg::MPU_CTRL_ADDR);
  wire logic wr_rsel = wr_ok & (a_q == mpu_pkg::MPU_RSEL_ADDR);
  wire logic wr_base = wr_ok & is_base;
  wire logic wr_region_attr_size = wr_ok & is_region_attr_size;
  wire logic base_valid = hwdata[mpu_pkg::RBASE_VALID_BIT];

  // Base write target: written field when valid, else current select
  wire logic [2:0] base_tgt = base_valid ? hwdata[2:0] : rsel_q;

  // Control and region select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= mpu_pkg::MPU_CTRL_RST;
      rsel_q <= mpu_pkg::MPU_RSEL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[2:0];
      end
      if (wr_rsel) begin
        rsel_q <= hwdata[2:0];
      end else if (wr_base && base_valid) begin
        rsel_q <= hwdata[2:0];
      end
    end
  end

  // Region storage, aliases write the same words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < mpu_pkg::MPU_NREG; i++) begin
        base_q[i] <= mpu_pkg::MPU_RBASE_RST;
        region_attr_size_q[i] <= mpu_pkg::MPU_REGION_ATTR_SIZE_RST;
      end
    end else begin
      if (wr_base) begin
        base_q[base_tgt] <= hwdata[31:mpu_pkg::RBASE_ADDR_LSB];
      end
      if (wr_region_attr_size) begin
        region_attr_size_q[rsel_q] <= hwdata & mpu_pkg::REGION_ATTR_SIZE_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode
  wire logic [31:0] cap_word = {8'h00, mpu_pkg::MPU_IREG_CNT,
                                mpu_pkg::MPU_DREG_CNT, 7'h00,
                                mpu_pkg::MPU_SPLIT_MAP};
  wire logic [31:0] ctrl_word = {29'h00000000, ctrl_q};
  wire logic [31:0] rsel_word = {29'h00000000, rsel_q};
  wire logic [31:0] base_word = {base_q[rsel_q], 2'h0, rsel_q};
  wire logic [31:0] region_attr_size_word = region_attr_size_q[rsel_q];
  wire logic [31:0] rd_mux =
    (a_q == mpu_pkg::MPU_CAP_ADDR) ? cap_word :
    (a_q == mpu_pkg::MPU_CTRL_ADDR) ? ctrl_word :
    (a_q == mpu_pkg::MPU_RSEL_ADDR) ? rsel_word :
    is_base ? base_word :
    is_region_attr_size ? region_attr_size_word : 32'h00000000;

  // Read data held from the wait state until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (st_q == mpu_pkg::MPU_BUS_RD) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Region comparators, all in parallel on the one access address
  mpu_region_if rif [mpu_pkg::MPU_NREG] ();
  logic [mpu_pkg::MPU_NREG-1:0] hit_v;

  for (genvar g = 0; g < mpu_pkg::MPU_NREG; g++) begin : g_reg
    assign rif[g].en = region_attr_size_q[g][mpu_pkg::REGION_ATTR_SIZE_EN_BIT];
    assign rif[g].size = region_attr_size_q[g][mpu_pkg::REGION_ATTR_SIZE_SIZE_LSB +: 5];
    assign rif[g].srd = region_attr_size_q[g][mpu_pkg::REGION_ATTR_SIZE_SRD_LSB +: 8];
    assign rif[g].base = base_q[g];
    assign rif[g].addr = acc_addr;
    assign hit_v[g] = rif[g].hit;
    mpu_region_match u_match (
      .rif(rif[g])
    );
  end

  // Highest-numbered hit wins
  logic [2:0] win;
  always_comb begin
    win = 3'h0;
    for (int i = 0; i < mpu_pkg::MPU_NREG; i++) begin
      if (hit_v[i]) begin
        win = 3'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Winning region attributes
  wire logic any_hit = |hit_v;
  wire logic [31:0] wattr = region_attr_size_q[win];
  wire logic w_xn = wattr[mpu_pkg::REGION_ATTR_SIZE_XN_BIT];
  wire logic [2:0] w_ap = wattr[mpu_pkg::REGION_ATTR_SIZE_AP_LSB +: 3];
  wire logic [2:0] w_tex = wattr[mpu_pkg::REGION_ATTR_SIZE_TEX_LSB +: 3];
  wire logic w_c = wattr[mpu_pkg::REGION_ATTR_SIZE_C_BIT];
  wire logic w_b = wattr[mpu_pkg::REGION_ATTR_SIZE_B_BIT];
  wire logic w_s = wattr[mpu_pkg::REGION_ATTR_SIZE_S_BIT];
  wire logic w_so = (w_tex == 3'h0) & ~w_c & ~w_b;

  // Permission check of the winning region
  logic ap_deny;
  always_comb begin
    case (w_ap)
      mpu_pkg::AP_NONE: ap_deny = 1'b1;
      mpu_pkg::AP_PRIV_RW: ap_deny = ~acc_priv;
      mpu_pkg::AP_USER_RO: ap_deny = ~acc_priv & acc_write;
      mpu_pkg::AP_FULL: ap_deny = 1'b0;
      mpu_pkg::AP_RSVD: ap_deny = 1'b1;
      mpu_pkg::AP_PRIV_RO: ap_deny = ~acc_priv | acc_write;
      default: ap_deny = acc_write;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Enables and fixed windows
  wire logic en = ctrl_q[mpu_pkg::CTRL_EN_BIT];
  wire logic hfnmi = ctrl_q[mpu_pkg::CTRL_HFNMI_BIT];
  wire logic privdef = ctrl_q[mpu_pkg::CTRL_PRIVDEF_BIT] & en;
  wire logic bypass = en & acc_hi_prio & ~hfnmi;
  wire logic active = en & ~bypass;
  wire logic in_scs = (acc_addr & mpu_pkg::SCS_MASK) == mpu_pkg::SCS_BASE;
  wire logic in_vtab = acc_addr < mpu_pkg::VTAB_LIMIT;
  wire logic use_region = active & any_hit & ~in_scs & ~in_vtab;

  // Fault decision, same cycle as the address
  logic fault_c;
  always_comb begin
    if (in_scs) begin
      fault_c = acc_fetch;
    end else if (!active) begin
      fault_c = 1'b0;
    end else if (in_vtab) begin
      fault_c = 1'b0;
    end else if (any_hit) begin
      fault_c = (acc_fetch & w_xn) | ap_deny;
    end else begin
      fault_c = ~(privdef & acc_priv);
    end
  end

  // Decision and attributes to the core
  assign acc_fault = acc_valid & fault_c;
  assign acc_region_hit = use_region;
  assign acc_region = use_region ? win : 3'h0;
  assign acc_default_map = ~in_scs & ~use_region;
  assign acc_xn = in_scs | (use_region & w_xn);
  assign acc_strong_order = in_scs | (use_region & w_so);
  assign acc_shareable = acc_strong_order | (use_region & w_s);
  assign acc_mem_attr = use_region ? {w_tex, w_c, w_b} : 5'h00;

endmodule // mpu_top
`default_nettype wire

// ### shared/mpu_pkg.sv
/*
  Constants shared by the protection unit: register addresses, field
  positions, reset values, region limits and bus states.
  Assumes a 32-bit AHB-Lite register port and eight regions.
*/
package mpu_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] MPU_CAP_ADDR = 32'hE000ED90;
  localparam logic [31:0] MPU_CTRL_ADDR = 32'hE000ED94;
  localparam logic [31:0] MPU_RSEL_ADDR = 32'hE000ED98;
  localparam logic [31:0] MPU_RBASE_ADDR = 32'hE000ED9C;
  localparam logic [31:0] MPU_REGION_ATTR_SIZE_ADDR = 32'hE000EDA0;
  localparam logic [31:0] MPU_RBASE_A1_ADDR = 32'hE000EDA4;
  localparam logic [31:0] MPU_REGION_ATTR_SIZE_ALIAS_1_ADDR = 32'hE000EDA8;
  localparam logic [31:0] MPU_RBASE_A2_ADDR = 32'hE000EDAC;
  localparam logic [31:0] MPU_REGION_ATTR_SIZE_ALIAS_2_ADDR = 32'hE000EDB0;
  localparam logic [31:0] MPU_RBASE_A3_ADDR = 32'hE000EDB4;
  localparam logic [31:0] MPU_REGION_ATTR_SIZE_ALIAS_3_ADDR = 32'hE000EDB8;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and capability fields
  localparam logic [31:0] MPU_CAP_RST = 32'h00000800;
  localparam logic [2:0] MPU_CTRL_RST = 3'h0;
  localparam logic [2:0] MPU_RSEL_RST = 3'h0;
  localparam logic [26:0] MPU_RBASE_RST = 27'h0000000;
  localparam logic [31:0] MPU_REGION_ATTR_SIZE_RST = 32'h00000000;
  localparam logic [7:0] MPU_IREG_CNT = 8'h00;
  localparam logic [7:0] MPU_DREG_CNT = 8'h08;
  localparam logic MPU_SPLIT_MAP = 1'b0;
  localparam int MPU_NREG = 8;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HFNMI_BIT = 1;
  localparam int CTRL_PRIVDEF_BIT = 2;
  localparam int RBASE_VALID_BIT = 4;
  localparam int RBASE_ADDR_LSB = 5;
  localparam int REGION_ATTR_SIZE_EN_BIT = 0;
  localparam int REGION_ATTR_SIZE_SIZE_LSB = 1;
  localparam int REGION_ATTR_SIZE_SRD_LSB = 8;
  localparam int REGION_ATTR_SIZE_B_BIT = 16;
  localparam int REGION_ATTR_SIZE_C_BIT = 17;
  localparam int REGION_ATTR_SIZE_S_BIT = 18;
  localparam int REGION_ATTR_SIZE_TEX_LSB = 19;
  localparam int REGION_ATTR_SIZE_AP_LSB = 24;
  localparam int REGION_ATTR_SIZE_XN_BIT = 28;
  localparam logic [31:0] REGION_ATTR_SIZE_WMASK = 32'h173FFF3F;

  ////////////////////////////////////////////////////////////////////////
  // Region geometry and fixed address windows
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SRD_MIN_SIZE = 5'h07;
  localparam logic [31:0] SCS_BASE = 32'hE000E000;
  localparam logic [31:0] SCS_MASK = 32'hFFFFF000;
  localparam logic [31:0] VTAB_LIMIT = 32'h00000400;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////
  // Access permission codes
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_RSVD = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;

  // Register port states
  typedef enum logic [3:0] {
    MPU_BUS_IDLE = 4'b0001,
    MPU_BUS_WR = 4'b0010,
    MPU_BUS_RD = 4'b0100,
    MPU_BUS_RDO = 4'b1000
  } mpu_bus_st_t;

endpackage

// ### shared/mpu_region_if.sv
/*
  Carrier between the unit and one region comparator: region setup and
  the access address out, the hit answer back.
  Assumes one instance per region.
*/
`timescale 1ns/1ns
`default_nettype none
interface mpu_region_if;
  logic en;
  logic [4:0] size;
  logic [7:0] srd;
  logic [26:0] base;
  logic [31:0] addr;
  logic hit;
  modport cfg (output en, size, srd, base, addr, input hit);
  modport chk (input en, size, srd, base, addr, output hit);
endinterface
`default_nettype wire

// ### rtl/mpu_region_match.sv
/*
  One region comparator: address against base, size and subregions.
  Assumes the region fields are stable while an access is checked.
*/
`timescale 1ns/1ns
`default_nettype none
module mpu_region_match (
  // Region setup and answer
  mpu_region_if.chk rif
);

  // Sizes below the smallest region act as the smallest
  wire logic [4:0] sz_eff = (rif.size < mpu_pkg::SIZE_MIN) ?
                            mpu_pkg::SIZE_MIN : rif.size;
  wire logic [5:0] sh = {1'b0, sz_eff} + 6'h01;
  wire logic [31:0] mask = 32'hFFFFFFFF << sh;
  wire logic [31:0] base_full = {rif.base, 5'h00};
  wire logic in_rng = ((rif.addr ^ base_full) & mask) == 32'h00000000;

  // Eighth of the region holding the address
  wire logic [4:0] sub_sh = sz_eff - 5'h02;
  wire logic [31:0] sub_w = rif.addr >> sub_sh;
  wire logic [2:0] sub = sub_w[2:0];
  wire logic sub_ok = (sz_eff < mpu_pkg::SRD_MIN_SIZE) | ~rif.srd[sub];

  assign rif.hit = rif.en & in_rng & sub_ok;

endmodule // mpu_region_match
`default_nettype wire

// ### sim/mpu_top_props.sv
/*
  Checker for the protection unit: register port timing and access
  decision relations seen at the top ports.
  Assumes hready is tied to hreadyout, one slave on the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module mpu_top_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register port
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Access decision
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_fetch,
  input wire logic acc_fault,
  input wire logic acc_region_hit,
  input wire logic [2:0] acc_region,
  input wire logic acc_xn,
  input wire logic acc_strong_order,
  input wire logic acc_shareable,
  input wire logic [4:0] acc_mem_attr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  // Decodes and bus steps
  wire logic in_scs = (acc_addr & mpu_pkg::SCS_MASK) == mpu_pkg::SCS_BASE;
  wire logic take = hsel && htrans[1] && hready;
  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // Properties
  read_wait_a: assert property (rd_take |=> rd_answer)
    else $error("read answer not after one wait");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  scs_fetch_a: assert property (acc_valid && acc_fetch && in_scs |-> acc_fault)
    else $error("control space fetch not faulted");
  scs_attr_a: assert property (acc_valid && in_scs |-> acc_xn && acc_strong_order)
    else $error("control space attributes wrong");
  scs_permit_a: assert property (acc_valid && !acc_fetch && in_scs |-> !acc_fault)
    else $error("control space data access faulted");
  strong_share_a: assert property (acc_strong_order |-> acc_shareable)
    else $error("strongly ordered not shareable");
  hit_order_a: assert property (acc_region_hit && !in_scs |->
    acc_strong_order == (acc_mem_attr == 5'h00))
    else $error("strong order does not follow attributes");
  no_hit_a: assert property (!acc_region_hit |-> acc_region == 3'h0 && acc_mem_attr == 5'h00)
    else $error("region fields set without a hit");
  fault_gate_a: assert property (!acc_valid |-> !acc_fault)
    else $error("fault without an access");
  xn_fetch_a: assert property (acc_valid && acc_fetch && acc_region_hit && acc_xn |-> acc_fault)
    else $error("fetch from execute-never region not faulted");
endmodule // mpu_top_props
bind mpu_top mpu_top_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .acc_valid, .acc_addr, .acc_fetch, .acc_fault, .acc_region_hit, .acc_region,
  .acc_xn, .acc_strong_order, .acc_shareable, .acc_mem_attr);
`default_nettype wire

// ### sim/mpu_core_model.sv
/*
  Core model: issues one fetch or data access per call.
  Assumes the unit answers in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module mpu_core_model (
  // Clock
  input wire logic hclk,
  // Access toward the unit
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_fetch,
  output logic acc_write,
  output logic acc_priv,
  output logic acc_hi_prio
);
  // Idle core at time zero
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_fetch = 1'b0;
    acc_write = 1'b0;
    acc_priv = 1'b0;
    acc_hi_prio = 1'b0;
  end
  // One access, held until the caller has looked at the answer
  task automatic issue(input logic [31:0] a, input logic f, w, p, h);
    @(posedge hclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_fetch <= f;
    acc_write <= w;
    acc_priv <= p;
    acc_hi_prio <= h;
    @(negedge hclk);
  endtask
endmodule // mpu_core_model
`default_nettype wire

// ### sim/memory_protection_unit_tb.sv
/*
  Self-checking bench: registers over AHB-Lite, then access checks.
  Assumes mpu_top with one slave, hready tied to hreadyout.
*/
`timescale 1ns/1ns
`default_nettype none
module memory_protection_unit_tb;
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize, acc_region;
  logic [31:0] haddr, hwdata, hrdata, acc_addr;
  logic hreadyout, hresp, acc_valid, acc_fetch, acc_write, acc_priv, acc_hi_prio;
  logic acc_fault, acc_region_hit, acc_default_map, acc_xn, acc_strong_order, acc_shareable;
  logic [4:0] acc_mem_attr;
  int errors = 0;
  int compares = 0;
  mpu_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .acc_valid, .acc_addr, .acc_fetch,
    .acc_write, .acc_priv, .acc_hi_prio, .acc_fault, .acc_region_hit, .acc_region,
    .acc_default_map, .acc_xn, .acc_strong_order, .acc_shareable, .acc_mem_attr);
  mpu_core_model core (.hclk, .acc_valid, .acc_addr, .acc_fetch, .acc_write, .acc_priv,
    .acc_hi_prio);
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic ck(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] s, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    ck({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(a, 1'b1, d, 3'h2, x);
  endtask
  task automatic rd_ck(input logic [31:0] a, exp);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, 3'h2, x);
    ck(x, exp);
  endtask
  task automatic acc(input logic [31:0] a, input logic f, p, h, ef, input logic [2:0] er);
    core.issue(a, f, 1'b0, p, h);
    ck({31'h0, acc_fault}, {31'h0, ef});
    ck({29'h0, acc_region}, {29'h0, er});
  endtask
  // Data access with a write flag, fault only
  task automatic acc_d(input logic [31:0] a, input logic w, p, ef);
    core.issue(a, 1'b0, w, p, 1'b0);
    ck({31'h0, acc_fault}, {31'h0, ef});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] x;
    for (int i = 0; i < 12; i++) begin
      rd_ck(mpu_pkg::MPU_CAP_ADDR + 32'(4 * i), i == 0 ? mpu_pkg::MPU_CAP_RST : 32'h0);
    end
    wr(mpu_pkg::MPU_CAP_ADDR, 32'h0);
    rd_ck(mpu_pkg::MPU_CAP_ADDR, 32'h00000800);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'hFFFFFFFF);
    rd_ck(mpu_pkg::MPU_CTRL_ADDR, 32'h00000007);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h0);
    bus(mpu_pkg::MPU_CTRL_ADDR, 1'b1, 32'h00000007, 3'h0, x);
    rd_ck(mpu_pkg::MPU_CTRL_ADDR, 32'h00000000);
    wr(mpu_pkg::MPU_RSEL_ADDR, 32'h000000FF);
    rd_ck(mpu_pkg::MPU_RSEL_ADDR, 32'h00000007);
  endtask
  task automatic t_alias();
    logic [31:0] ba, ra;
    for (int k = 0; k < 4; k++) begin
      ba = mpu_pkg::MPU_RBASE_ADDR + 32'(8 * k);
      ra = mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR + 32'(8 * k);
      wr(ba, 32'h20000010 | 32'(k));
      rd_ck(mpu_pkg::MPU_RSEL_ADDR, 32'(k));
      rd_ck(ba, 32'h20000000 | 32'(k));
      wr(ra, 32'hFFFFFFFE);
      rd_ck(mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR, 32'h173FFF3E);
    end
  endtask
  task automatic t_check();
    wr(mpu_pkg::MPU_RBASE_ADDR, 32'h20000011);
    wr(mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR, 32'h03000013);
    wr(mpu_pkg::MPU_RBASE_ADDR, 32'h20000013);
    wr(mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR, 32'h13020009);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h1);
    acc(32'h20000100, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1);
    ck({30'h0, acc_strong_order, acc_shareable}, 32'h3);
    acc(32'h20000010, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
    ck({27'h0, acc_mem_attr}, 32'h2);
    acc(32'h20000010, 1'b1, 1'b1, 1'b0, 1'b1, 3'h3);
    ck({30'h0, acc_region_hit, acc_xn}, 32'h3);
    acc(32'h20000100, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
    acc(32'h30000000, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0);
    acc(32'h00000100, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    acc(32'hE000ED00, 1'b1, 1'b1, 1'b0, 1'b1, 3'h0);
    ck({30'h0, acc_region_hit, acc_xn}, 32'h1);
    acc(32'h30000000, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h3);
    acc(32'h30000000, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h5);
    acc(32'h30000000, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    ck({31'h0, acc_default_map}, 32'h1);
    acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    acc(32'h20000010, 1'b1, 1'b1, 1'b0, 1'b1, 3'h3);
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h4);
    acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    acc(32'hE000ED00, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
  endtask
  // Every permission code against privileged and user reads and writes
  task automatic t_perm();
    logic [31:0] tbl;
    tbl = 32'h557F013F;
    wr(mpu_pkg::MPU_CTRL_ADDR, 32'h1);
    wr(mpu_pkg::MPU_RBASE_ADDR, 32'h40000015);
    for (int ap = 0; ap < 8; ap++) begin
      wr(mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR, 32'h00000013 | (32'(ap) << 24));
      acc_d(32'h40000100, 1'b0, 1'b1, tbl[4 * ap + 3]);
      acc_d(32'h40000100, 1'b1, 1'b1, tbl[4 * ap + 2]);
      acc_d(32'h40000100, 1'b0, 1'b0, tbl[4 * ap + 1]);
      acc_d(32'h40000100, 1'b1, 1'b0, tbl[4 * ap]);
    end
    wr(mpu_pkg::MPU_REGION_ATTR_SIZE_ADDR, 32'h03000213);
    acc(32'h40000080, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0);
    acc(32'h40000100, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Closing
  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_alias();
    t_check();
    t_perm();
    wrap_up();
  end
endmodule // memory_protection_unit_tb
`default_nettype wire
